// ---- verilog/dsr_pin_mux.sv ----
// top of the deserializer output pin mode and multiplexing logic
//
// Contract
// RQ1 - decode low, high, open width strap
// RQ2 - same width strap on both link ends
// RQ3 - mode input picks base or bypass
// RQ4 - sample address straps, then become outputs
// RQ5 - aux pins carry control only in high-bandwidth
// RQ6 - protocol level at power-up picks uart/i2c
// RQ7 - control pins open-drain only, external pullups
// RQ8 - low power-down input enters power-down
// RQ9 - error output active low, released in power-down
// RQ10 - lock pulled low unless locked and aligned
// RQ11 - audio clocks output unless source bit set
// RQ12 - immunity default from data pin strap
// RQ13 - software may overwrite immunity bit
// RQ14 - audio off: data pin is extra output
// RQ15 - outputs 27, 28 by width mode
// RQ16 - outputs 21..26 floated in 24-bit mode
// RQ17 - outputs 18..20 become syncs when needed
// RQ18 - outputs valid on selected pixel clock edge
// RQ19 - pixel clock rate limited per width mode
// RQ20 - audio carries stereo i2s or tdm
// RQ21 - active-low enable gates clock and outputs
// RQ22 - protocol input high i2c, low uart
// RQ23 - latched straps hold until next wake
module dsr_pin_mux
  import dsr_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              bus_width_select_i,
  input  wire logic              bus_width_open_i,
  input  wire logic              link_mode_select_i,
  input  wire logic              power_down_n_i,
  input  wire logic              output_enable_n_i,
  input  wire logic              ctrl_protocol_select_i,
  input  wire logic              addr_strap_bit0_i,
  input  wire logic              addr_strap_bit1_i,
  input  wire logic              addr_strap_bit2_i,
  input  wire logic              high_immunity_strap_i,
  input  wire logic              av_status_irq_i,
  input  wire logic [AUX_W-1:0]  aux_ctrl_i,
  input  wire logic [DOUT_W-1:0] pix_data_i,
  input  wire logic              pix_hs_i,
  input  wire logic              pix_vs_i,
  input  wire logic              pix_de_i,
  input  wire logic              encrypt_en_i,
  input  wire logic              pclk_tick_i,
  input  wire logic              pclk_rise_sel_i,
  input  wire logic              cc_rx_pull_i,
  input  wire logic              cc_tx_pull_i,
  input  wire logic              cc_rx_pin_i,
  input  wire logic              cc_tx_pin_i,
  input  wire logic              data_error_i,
  input  wire logic              pll_locked_i,
  input  wire logic              word_aligned_i,
  input  wire logic              audio_clock_source_sel_i,
  input  wire logic              audio_enable_i,
  input  wire logic              aud_ws_i,
  input  wire logic              aud_sck_i,
  input  wire logic              aud_sd_i,
  input  wire logic              aux_sd_i,
  input  wire logic              ws_pin_i,
  input  wire logic              sck_pin_i,
  input  wire logic              hi_imm_wr_i,
  input  wire logic              hi_imm_wdata_i,
  output dsr_bw_t                bus_width_mode_o,
  output logic                   bypass_mode_o,
  output logic                   power_down_o,
  output logic [2:0]             dev_addr_o,
  output logic                   ctrl_proto_i2c_o,
  output logic                   cc_rx_o,
  output logic                   cc_tx_o,
  output logic                   high_immunity_bit_o,
  output logic                   ext_ws_o,
  output logic                   ext_sck_o,
  output dsr_pin_t               aux_ctrl_out0_o,
  output dsr_pin_t               aux_ctrl_out3_o,
  output dsr_pin_t               irq_pin_o,
  output dsr_pin_t               cc_rx_pin_o,
  output dsr_pin_t               cc_tx_pin_o,
  output dsr_pin_t               error_n_pin_o,
  output dsr_pin_t               lock_pin_o,
  output dsr_pin_t               ws_pin_o,
  output dsr_pin_t               sck_pin_o,
  output dsr_pin_t               sd_pin_o,
  output dsr_pin_t               pixel_clock_out_o,
  output logic [DOUT_W-1:0]      dout_o,
  output logic [DOUT_W-1:0]      dout_oe_o
);

  localparam logic [SPACE_W-1:0] HALF_N = SPACE_W'(PCLK_HALF_N);
  localparam logic [SPACE_W-1:0] HALF_W = SPACE_W'(PCLK_HALF_W);
  localparam logic [SPACE_W-1:0] SPACE_MAX = '1;

  dsr_bw_t           bw_mode;       // decoded width mode
  logic              pd;            // power-down active
  logic              strap_done;    // shared pins now outputs
  logic              strap_cap;     // one-cycle capture strobe
  dsr_strap_t        strap_pins;    // raw strap pin levels
  dsr_strap_t        strap;         // held strap values
  logic              hi_imm_q;      // high-immunity control bit
  logic              out_en;        // parallel side enabled
  logic              hb_mode;       // high-bandwidth mode
  logic              sync_sel;      // outputs 18..20 carry syncs
  logic [SPACE_W-1:0] space_q;      // cycles since last clock edge
  logic [SPACE_W-1:0] half_min;     // least half period now
  logic              pclk_step;     // accepted divider tick
  logic              pclk_q;        // pixel clock level
  logic              load_out;      // output word update strobe
  logic [DOUT_W-1:0] dout_d;        // next parallel word
  logic [DOUT_W-1:0] dout_q;        // registered parallel word
  logic [DOUT_W-1:0] dout_oe_d;     // next per-bit enables
  logic [DOUT_W-1:0] dout_oe_q;     // registered per-bit enables
  dsr_pin_t          aux0_q;        // shared pin, addr bit 0
  dsr_pin_t          aux3_q;        // shared pin, addr bit 1
  dsr_pin_t          irq_q;         // shared pin, addr bit 2
  dsr_pin_t          ws_q;          // audio word select pin
  dsr_pin_t          sck_q;         // audio bit clock pin
  dsr_pin_t          sd_q;          // audio data / strap pin

  // RQ1 width decode
  // open wins over the level, since a floating pin reads either way
  always_comb
  begin
    if (bus_width_open_i)
      bw_mode = DSR_BW_HB;
    else if (bus_width_select_i)
      bw_mode = DSR_BW_32;
    else
      bw_mode = DSR_BW_24;
  end

  // RQ2 shared width strap
  // the serializer sees the same strap; nothing here can check it
  assign bus_width_mode_o = bw_mode;
  assign hb_mode          = (bw_mode == DSR_BW_HB);

  // RQ3 link mode select
  // the pulldown on the pin makes base mode the default
  assign bypass_mode_o = link_mode_select_i;

  // RQ8 power-down entry
  assign pd           = !power_down_n_i;
  assign power_down_o = pd;

  // RQ21 output enable gate
  assign out_en = !output_enable_n_i && !pd;

  // RQ4 strap pin sampling
  assign strap_pins.addr = {addr_strap_bit2_i, addr_strap_bit1_i,
                            addr_strap_bit0_i};
  assign strap_pins.hi_imm    = high_immunity_strap_i;
  assign strap_pins.proto_i2c = ctrl_protocol_select_i;

  // RQ23 straps held per wake
  dsr_strap_latch u_strap (
    .mclk_i       (mclk_i),
    .sys_rst_i    (sys_rst_i),
    .power_down_i (pd),
    .pins_i       (strap_pins),
    .done_o       (strap_done),
    .capture_o    (strap_cap),
    .strap_o      (strap)
  );

  assign dev_addr_o = strap.addr;

  // RQ6 protocol at power-up
  // RQ22 high means i2c
  assign ctrl_proto_i2c_o = strap.proto_i2c;
  assign cc_rx_o          = cc_rx_pin_i;
  assign cc_tx_o          = cc_tx_pin_i;

  // RQ12 immunity strap default
  // RQ13 software overwrite
  // a write in the capture cycle loses: the wake reload must stand
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      hi_imm_q <= STRAP_RST.hi_imm;
    else if (strap_cap)
      hi_imm_q <= high_immunity_strap_i;
    else if (hi_imm_wr_i && strap_done)
      hi_imm_q <= hi_imm_wdata_i;
  end

  assign high_immunity_bit_o = hi_imm_q;

  // RQ7 open-drain control pins
  dsr_od_drv u_rx_od (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .pull_low_i (cc_rx_pull_i),
    .release_i  (pd),
    .pin_o      (cc_rx_pin_o)
  );

  dsr_od_drv u_tx_od (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .pull_low_i (cc_tx_pull_i),
    .release_i  (pd),
    .pin_o      (cc_tx_pin_o)
  );

  // RQ9 error pulls low, released in power-down
  dsr_od_drv u_err_od (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .pull_low_i (data_error_i),
    .release_i  (pd),
    .pin_o      (error_n_pin_o)
  );

  // RQ10 lock released when locked and aligned, and always in power-down
  dsr_od_drv u_lock_od (
    .mclk_i     (mclk_i),
    .sys_rst_i  (sys_rst_i),
    .pull_low_i (!(pll_locked_i && word_aligned_i)),
    .release_i  (pd),
    .pin_o      (lock_pin_o)
  );

  // RQ5 aux pins, control only in high-bandwidth
  // other modes hold the pins low, as unused outputs are pulled low
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      aux0_q <= '0;
      aux3_q <= '0;
      irq_q  <= '0;
    end
    else
    begin
      aux0_q.oe <= strap_done && out_en;
      aux3_q.oe <= strap_done && out_en;
      aux0_q.o  <= hb_mode && aux_ctrl_i[0];
      aux3_q.o  <= hb_mode && aux_ctrl_i[3];
      irq_q.oe  <= strap_done;
      irq_q.o   <= av_status_irq_i;
    end
  end

  // RQ11 audio clock direction
  // RQ20 i2s and tdm framing come from the audio engine upstream
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      ws_q  <= '0;
      sck_q <= '0;
    end
    else
    begin
      ws_q.oe  <= !audio_clock_source_sel_i && !pd;
      sck_q.oe <= !audio_clock_source_sel_i && !pd;
      ws_q.o   <= aud_ws_i;
      sck_q.o  <= aud_sck_i;
    end
  end

  assign ext_ws_o  = ws_pin_i;
  assign ext_sck_o = sck_pin_i;

  // RQ14 data pin reuse
  // it stays an input during the strap phase so the strap reads true
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      sd_q <= '0;
    else
    begin
      sd_q.oe <= strap_done && !pd;
      sd_q.o  <= audio_enable_i ? aud_sd_i : aux_sd_i;
    end
  end

  // RQ19 pixel clock rate limit
  // ticks closer than the half period are dropped, not queued
  assign half_min  = (bw_mode == DSR_BW_32) ? HALF_W : HALF_N;
  assign pclk_step = pclk_tick_i && (space_q >= half_min) && out_en;

  // half-period counter, saturating so long gaps stay legal
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      space_q <= SPACE_MAX;
    else if (pclk_step)
      space_q <= SPACE_W'(1);
    else if (space_q != SPACE_MAX)
      space_q <= space_q + SPACE_W'(1);
  end

  // pixel clock level toggles on each accepted tick
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      pclk_q <= PCLK_RST;
    else if (pclk_step)
      pclk_q <= !pclk_q;
  end

  // RQ18 data changes on the edge away from the selected one
  assign load_out = pclk_step && ((!pclk_q) != pclk_rise_sel_i);

  // RQ17 sync outputs in high-bandwidth or when encrypting
  assign sync_sel = hb_mode || encrypt_en_i;

  // per-bit value and enable for the parallel outputs
  genvar gi;
  generate
    for (gi = 0; gi < DOUT_W; gi++)
    begin : g_dout
      if (gi >= SYNC_LSB && gi <= SYNC_MSB)
      begin : g_sync
        logic [2:0] syncs;
        assign syncs = {pix_de_i, pix_vs_i, pix_hs_i};
        // RQ17 sync replaces data
        assign dout_d[gi] = sync_sel ? syncs[gi - SYNC_LSB] : pix_data_i[gi];
        assign dout_oe_d[gi] = out_en;
      end
      else if (gi >= AUXP_LSB)
      begin : g_auxp
        // RQ15 aux ctrl 1, 2 in high-bandwidth
        assign dout_d[gi] = hb_mode ? aux_ctrl_i[gi - AUXP_LSB + 1]
                                    : pix_data_i[gi];
        assign dout_oe_d[gi] = out_en && (bw_mode != DSR_BW_24);
      end
      else if (gi >= WIDE_LSB)
      begin : g_wide
        // RQ16 floated in 24-bit mode
        assign dout_d[gi]    = pix_data_i[gi];
        assign dout_oe_d[gi] = out_en && (bw_mode != DSR_BW_24);
      end
      else
      begin : g_base
        assign dout_d[gi]    = pix_data_i[gi];
        assign dout_oe_d[gi] = out_en;
      end
    end
  endgenerate

  // RQ18 output word register
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      dout_q <= '0;
    else if (load_out)
      dout_q <= dout_d;
  end

  // RQ21 enables register the gate every cycle, so disable lands one cycle later
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      dout_oe_q <= '0;
    else
      dout_oe_q <= dout_oe_d;
  end

  assign dout_o               = dout_q;
  assign dout_oe_o            = dout_oe_q;
  assign pixel_clock_out_o.o  = pclk_q;
  assign pixel_clock_out_o.oe = out_en;
  assign aux_ctrl_out0_o      = aux0_q;
  assign aux_ctrl_out3_o      = aux3_q;
  assign irq_pin_o            = irq_q;
  assign ws_pin_o             = ws_q;
  assign sck_pin_o            = sck_q;
  assign sd_pin_o             = sd_q;

  // checks on the behaviour above
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);

  sequence wake_s;
    !strap_done && !pd;
  endsequence

  sequence held_s;
    strap_done [*2];
  endsequence

  bw_decode_a: assert property ( // RQ1
    (bus_width_open_i |-> bw_mode == DSR_BW_HB) and
    (!bus_width_open_i |-> bw_mode ==
      (bus_width_select_i ? DSR_BW_32 : DSR_BW_24)))
    else $error("width mode decode wrong");

  link_mode_a: assert property ( // RQ3
    bypass_mode_o == link_mode_select_i)
    else $error("bypass mode not following input");

  strap_capture_a: assert property ( // RQ4
    wake_s |=> strap_done && strap == $past(strap_pins)
      && !$past(aux0_q.oe))
    else $error("straps not captured on wake");

  strap_hold_a: assert property ( // RQ23
    held_s |-> $stable(strap))
    else $error("latched straps changed");

  aux_mode_a: assert property ( // RQ5
    aux0_q.oe && !$past(hb_mode) |-> !aux0_q.o && !aux3_q.o)
    else $error("aux pin driven outside high-bandwidth");

  od_release_a: assert property ( // RQ9
    pd [*2] |-> !error_n_pin_o.oe && !lock_pin_o.oe)
    else $error("status pins pulled low in power-down");

  lock_follow_a: assert property ( // RQ10
    !pd && !(pll_locked_i && word_aligned_i) |=> pd || lock_pin_o.oe)
    else $error("lock released while unlocked");

  audio_dir_a: assert property ( // RQ11
    audio_clock_source_sel_i |=> !ws_q.oe && !sck_q.oe)
    else $error("audio clocks driven with external source");

  imm_write_a: assert property ( // RQ13
    hi_imm_wr_i && strap_done && !strap_cap |=>
      hi_imm_q == $past(hi_imm_wdata_i))
    else $error("immunity bit write lost");

  narrow_float_a: assert property ( // RQ16
    $past(bw_mode) == DSR_BW_24 |-> dout_oe_q[DOUT_W-1:WIDE_LSB] == '0)
    else $error("wide outputs driven in 24-bit mode");

  pclk_rate_a: assert property ( // RQ19
    $changed(pclk_q) |-> $past(space_q) >= $past(half_min))
    else $error("pixel clock half period too short");

  out_gate_a: assert property ( // RQ21
    output_enable_n_i |=> !pixel_clock_out_o.oe || !output_enable_n_i
      ##0 dout_oe_q == '0)
    else $error("outputs driven while disabled");

endmodule

// ---- verilog/dsr_pkg.sv ----
// shared constants, modes and carrier types of the deserializer pin mux
package dsr_pkg;

  // three-level bus width decode, gray along 24 -> high-bandwidth -> 32
  typedef enum logic [1:0] {
    DSR_BW_24 = 2'h0,  // strap driven low
    DSR_BW_HB = 2'h1,  // strap left open
    DSR_BW_32 = 2'h3   // strap driven high
  } dsr_bw_t;

  // one pin that the device may drive: level and output enable
  typedef struct packed {
    logic o;   // level driven while oe is high
    logic oe;  // high while the device drives the pin
  } dsr_pin_t;

  // strap values caught when the pins leave their input phase
  typedef struct packed {
    logic [2:0] addr;       // device address strap bits 2..0
    logic       hi_imm;     // high-immunity default level
    logic       proto_i2c;  // control channel is i2c when high
  } dsr_strap_t;

  // parallel output word layout
  localparam int DOUT_W     = 29;  // parallel outputs 28..0
  localparam int SYNC_LSB   = 18;  // hs, vs, de share outputs 18..20
  localparam int SYNC_MSB   = 20;
  localparam int WIDE_LSB   = 21;  // outputs unused in 24-bit mode
  localparam int AUXP_LSB   = 27;  // outputs 27, 28 carry aux ctrl 1, 2
  localparam int AUX_W      = 4;   // aux control bits 3..0

  // reset values
  localparam dsr_strap_t STRAP_RST = '0;
  localparam logic       PCLK_RST  = 1'b0;

  // pixel clock limits and the system clock rate, both in kHz
  localparam int MCLK_KHZ        = 125000;
  localparam int PCLK_MAX_KHZ_N  = 104000;  // 24-bit and high-bandwidth
  localparam int PCLK_MAX_KHZ_W  = 78000;   // 32-bit
  // least half period of the pixel clock in system cycles, rounded up
  localparam int PCLK_HALF_N =
    (MCLK_KHZ + 2 * PCLK_MAX_KHZ_N - 1) / (2 * PCLK_MAX_KHZ_N);
  localparam int PCLK_HALF_W =
    (MCLK_KHZ + 2 * PCLK_MAX_KHZ_W - 1) / (2 * PCLK_MAX_KHZ_W);
  localparam int SPACE_W = 4;  // width of the half-period counter

endpackage

// ---- verilog/dsr_strap_latch.sv ----
// strap capture for the shared address, immunity and protocol pins
module dsr_strap_latch
  import dsr_pkg::*;
(
  input  wire logic       mclk_i,
  input  wire logic       sys_rst_i,
  input  wire logic       power_down_i,
  input  wire dsr_strap_t pins_i,
  output logic            done_o,
  output logic            capture_o,
  output dsr_strap_t      strap_o
);

  logic       done_q;   // pins have left the input phase
  dsr_strap_t strap_q;  // held strap values

  // capture on the first awake cycle after reset or power-down
  assign capture_o = !done_q && !power_down_i;

  // phase flag: power-down sends the pins back to input duty
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i || power_down_i)
      done_q <= 1'b0;
    else
      done_q <= 1'b1;
  end

  // values load once per wake and then ignore the pins entirely
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      strap_q <= STRAP_RST;
    else if (capture_o)
      strap_q <= pins_i;
  end

  assign done_o  = done_q;
  assign strap_o = strap_q;

endmodule

// ---- verilog/dsr_od_drv.sv ----
// registered open-drain driver: pulls low or lets the pullup win
module dsr_od_drv
  import dsr_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic sys_rst_i,
  input  wire logic pull_low_i,
  input  wire logic release_i,
  output dsr_pin_t  pin_o
);

  logic oe_q;  // pull-down active

  // release overrides any request; reset leaves the line to the pullup
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
      oe_q <= 1'b0;
    else
      oe_q <= pull_low_i && !release_i;
  end

  // the level is a constant zero, so the pin is never driven high
  assign pin_o.o  = 1'b0;
  assign pin_o.oe = oe_q;

endmodule

// ---- verification/dsr_link_model.sv ----
// serializer-side model: strap mirror, pixel ticks and payload word
module dsr_link_model
  import dsr_pkg::*;
(
  input  wire logic              mclk_i,
  input  wire logic              sys_rst_i,
  input  wire logic              slow_i,
  input  wire logic [DOUT_W-1:0] word_i,
  input  wire logic              bw_level_i,
  output logic                   bw_level_o,
  output logic                   tick_o,
  output logic [DOUT_W-1:0]      pix_o
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [1:0] div_q;  // slow pacing divider

  // shared width strap
  // both link ends see one strap level, so word formats agree
  assign bw_level_o = bw_level_i;

  // tick pacing: every cycle when prompt, one in four when slow
  always_ff @(posedge mclk_i)
  begin
    if (sys_rst_i)
    begin
      div_q  <= 2'h0;
      tick_o <= 1'b0;
    end
    else
    begin
      div_q  <= div_q + 2'h1;
      tick_o <= !slow_i || (div_q == 2'h0);
    end
  end

  // payload: one registered stage, as a real decoder would add
  always_ff @(posedge mclk_i)
    pix_o <= word_i;
endmodule

// ---- verification/dsr_pin_mux_bench.sv ----
// self-checking bench for the deserializer pin mode and output mux
module dsr_pin_mux_bench
  import dsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // stimulus, all set at time zero
  logic mclk_i = 1'b0, sys_rst_i = 1'b1, bw_lvl = 1'b0;
  logic bus_width_open_i = 1'b0, link_mode_select_i = 1'b0;
  logic power_down_n_i = 1'b1, output_enable_n_i = 1'b0;
  logic ctrl_protocol_select_i = 1'b1, addr_strap_bit0_i = 1'b1;
  logic addr_strap_bit1_i = 1'b0, addr_strap_bit2_i = 1'b1;
  logic high_immunity_strap_i = 1'b1, slow = 1'b0;
  logic [AUX_W-1:0] aux_ctrl_i = 4'hB;
  logic [DOUT_W-1:0] word = 29'h15A5A5A5;
  logic pix_hs_i = 1'b1, pix_vs_i = 1'b0, pix_de_i = 1'b1;
  logic encrypt_en_i = 1'b0, cc_rx_pull_i = 1'b0, cc_tx_pull_i = 1'b0;
  logic data_error_i = 1'b0, pll_locked_i = 1'b0, word_aligned_i = 1'b0;
  logic audio_clock_source_sel_i = 1'b0, audio_enable_i = 1'b1;
  logic aud_sd_i = 1'b0, aux_sd_i = 1'b0, ext_ws = 1'b0;
  logic hi_imm_wr_i = 1'b0, hi_imm_wdata_i = 1'b0;
  logic av_irq = 1'b0, aud_clk = 1'b0, rise_sel = 1'b1;
  // link side
  logic bw_strap, tick;
  logic [DOUT_W-1:0] pix;
  // observed outputs
  dsr_bw_t bus_width_mode_o;
  logic bypass_mode_o, power_down_o, ctrl_proto_i2c_o, cc_rx_o, cc_tx_o;
  logic high_immunity_bit_o, ext_ws_o, ext_sck_o;
  logic [2:0] dev_addr_o;
  dsr_pin_t aux_ctrl_out0_o, aux_ctrl_out3_o, irq_pin_o, cc_rx_pin_o;
  dsr_pin_t cc_tx_pin_o, error_n_pin_o, lock_pin_o, ws_pin_o, sck_pin_o;
  dsr_pin_t sd_pin_o, pixel_clock_out_o;
  logic [DOUT_W-1:0] dout_o, dout_oe_o;
  // packed views so that each compare is one full word
  wire logic [31:0] strap_view =
    32'({dev_addr_o, ctrl_proto_i2c_o, high_immunity_bit_o});
  wire logic [31:0] aux_view = 32'({aux_ctrl_out3_o.o, aux_ctrl_out0_o.o});
  int miscompares = 0;
  int n_compared = 0;
  logic [DOUT_W-1:0] dout_prev;
  logic pclk_prev;
  localparam dsr_bw_t MODES [3] = '{DSR_BW_HB, DSR_BW_24, DSR_BW_32};

  // open-drain lines
  // pull-ups hold the lines high unless the device pulls low
  wire logic rx_line = !(cc_rx_pin_o.oe && !cc_rx_pin_o.o);
  wire logic tx_line = !(cc_tx_pin_o.oe && !cc_tx_pin_o.o);
  // audio clock pins: device level, else external clock or pulldown
  wire logic ws_line = ws_pin_o.oe ? ws_pin_o.o : ext_ws;
  wire logic sck_line = sck_pin_o.oe ? sck_pin_o.o : ext_ws;

  dsr_link_model u_dsr_link_model (
    .mclk_i, .sys_rst_i, .slow_i(slow), .word_i(word),
    .bw_level_i(bw_lvl), .bw_level_o(bw_strap), .tick_o(tick), .pix_o(pix)
  );

  dsr_pin_mux u_dsr_pin_mux (
    .mclk_i, .sys_rst_i, .bus_width_select_i(bw_strap), .bus_width_open_i,
    .link_mode_select_i, .power_down_n_i, .output_enable_n_i,
    .ctrl_protocol_select_i, .addr_strap_bit0_i, .addr_strap_bit1_i,
    .addr_strap_bit2_i, .high_immunity_strap_i, .av_status_irq_i(av_irq),
    .aux_ctrl_i, .pix_data_i(pix), .pix_hs_i, .pix_vs_i, .pix_de_i,
    .encrypt_en_i, .pclk_tick_i(tick), .pclk_rise_sel_i(rise_sel),
    .cc_rx_pull_i, .cc_tx_pull_i, .cc_rx_pin_i(rx_line),
    .cc_tx_pin_i(tx_line), .data_error_i, .pll_locked_i, .word_aligned_i,
    .audio_clock_source_sel_i, .audio_enable_i, .aud_ws_i(aud_clk),
    .aud_sck_i(aud_clk), .aud_sd_i, .aux_sd_i, .ws_pin_i(ws_line),
    .sck_pin_i(sck_line), .hi_imm_wr_i, .hi_imm_wdata_i, .bus_width_mode_o,
    .bypass_mode_o, .power_down_o, .dev_addr_o, .ctrl_proto_i2c_o, .cc_rx_o,
    .cc_tx_o, .high_immunity_bit_o, .ext_ws_o, .ext_sck_o, .aux_ctrl_out0_o,
    .aux_ctrl_out3_o, .irq_pin_o, .cc_rx_pin_o, .cc_tx_pin_o, .error_n_pin_o,
    .lock_pin_o, .ws_pin_o, .sck_pin_o, .sd_pin_o, .pixel_clock_out_o,
    .dout_o, .dout_oe_o
  );

  // free-running system clock, 8 ns period
  initial forever #4 mclk_i = ~mclk_i;

  // verdict in one place
  task automatic tally_and_finish();
    if (miscompares == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  // one comparison, reported at once on mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("unexpected at %0t: got %0h want %0h", $time, got, exp);
    end
  endtask

  // advance to a falling edge, where inputs change and outputs settle
  task automatic step(input int n);
    repeat (n) @(negedge mclk_i);
  endtask

  // wait, bounded, until the masked word shows up, then compare it
  task automatic wait_out(input logic [28:0] mask, input logic [28:0] exp);
    int k;
    k = 0;
    while (((dout_o & mask) !== exp) && k < 40)
    begin
      step(1);
      k++;
    end
    chk(32'(dout_o & mask), 32'(exp));
  endtask

  // the selected clock edge must find the word unchanged; sampled on the
  // falling system edge so the registered outputs have settled
  always @(negedge mclk_i)
  begin
    if (!sys_rst_i && pclk_prev === !rise_sel &&
        pixel_clock_out_o.o === rise_sel)
      chk(32'(dout_o), 32'(dout_prev));
    dout_prev = dout_o;
    pclk_prev = pixel_clock_out_o.o;
  end

  // watchdog: a hang counts as a mismatch
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    miscompares++;
    tally_and_finish();
  end

  // main sequence
  initial
  begin
    logic [28:0] exp;
    logic [28:0] mask;
    step(20);
    sys_rst_i = 1'b0;
    step(3);
    chk(32'(dev_addr_o), 32'h5);
    chk(32'(ctrl_proto_i2c_o), 32'h1);
    chk(32'(high_immunity_bit_o), 32'h1);
    // pins move after capture; the latched values must not
    addr_strap_bit0_i = 1'b0;
    high_immunity_strap_i = 1'b0;
    ctrl_protocol_select_i = 1'b0;
    av_irq = 1'b1;
    step(3);
    chk(strap_view, 32'h17);
    chk(32'(irq_pin_o), 32'h3);
    hi_imm_wr_i = 1'b1;
    step(1);
    hi_imm_wr_i = 1'b0;
    step(2);
    chk(32'(high_immunity_bit_o), 32'h0);
    link_mode_select_i = 1'b1;
    step(1);
    chk(32'(bypass_mode_o), 32'h1);
    link_mode_select_i = 1'b0;
    step(1);
    chk(32'(bypass_mode_o), 32'h0);
    // each width mode: decode, enables, sync and aux routing
    for (int i = 0; i < 3; i++)
    begin
      bus_width_open_i = (i == 0);
      bw_lvl = (i == 2);
      word = word ^ 29'h1F0F00FF;
      step(4);
      chk(32'(bus_width_mode_o), 32'(MODES[i]));
      chk(32'(dout_oe_o[28:21]), (i == 1) ? 32'h0 : 32'hFF);
      chk(aux_view, (i == 0) ? 32'h3 : 32'h0);
      exp = word;
      mask = (i == 1) ? 29'h001FFFFF : 29'h1FFFFFFF;
      if (i == 0)
      begin
        exp[20:18] = 3'b101;
        exp[28:27] = 2'b01;
      end
      wait_out(mask, exp & mask);
    end
    encrypt_en_i = 1'b1;
    wait_out(29'h001C0000, 29'h00140000);
    encrypt_en_i = 1'b0;
    slow = 1'b1;
    word = 29'h0ABCDEF1;
    wait_out(29'h1FFFFFFF, 29'h0ABCDEF1);
    output_enable_n_i = 1'b1;
    step(3);
    chk(32'({pixel_clock_out_o.oe, dout_oe_o}), 32'h0);
    // falling edge selected from here: the word moves as the clock rises
    output_enable_n_i = 1'b0;
    rise_sel = 1'b0;
    word = 29'h01234567;
    wait_out(29'h1FFFFFFF, 29'h01234567);
    pll_locked_i = 1'b1;
    step(3);
    chk(32'(lock_pin_o), 32'h1);
    word_aligned_i = 1'b1;
    data_error_i = 1'b1;
    cc_rx_pull_i = 1'b1;
    aud_clk = 1'b1;
    step(3);
    chk(32'(lock_pin_o), 32'h0);
    chk(32'(error_n_pin_o), 32'h1);
    chk(32'({cc_rx_pin_o, cc_rx_o, cc_tx_o}), 32'h5);
    chk(32'({ws_pin_o, sck_pin_o}), 32'hF);
    audio_clock_source_sel_i = 1'b1;
    ext_ws = 1'b1;
    audio_enable_i = 1'b0;
    aux_sd_i = 1'b1;
    step(3);
    chk(32'({ws_pin_o.oe, sck_pin_o.oe, ext_ws_o, ext_sck_o}), 32'h3);
    chk(32'(sd_pin_o.o), 32'h1);
    audio_enable_i = 1'b1;
    step(3);
    chk(32'(sd_pin_o.o), 32'h0);
    // power-down releases indicators; wake reloads the straps
    pll_locked_i = 1'b0;
    power_down_n_i = 1'b0;
    step(3);
    chk(32'(power_down_o), 32'h1);
    chk(32'({error_n_pin_o.oe, lock_pin_o.oe}), 32'h0);
    addr_strap_bit1_i = 1'b1;
    addr_strap_bit2_i = 1'b0;
    high_immunity_strap_i = 1'b1;
    power_down_n_i = 1'b1;
    step(3);
    chk(strap_view, 32'h9);
    tally_and_finish();
  end
endmodule
